/* design/dapw_pkg.sv */
package dapw_pkg;

	// Register byte addresses on the AXI4-Lite slave.
	localparam logic [3:0] ch0_period_addr  = 4'h0;
	localparam logic [3:0] ch1_period_addr  = 4'h4;
	localparam logic [3:0] ch0_on_time_addr = 4'h8;
	localparam logic [3:0] ch1_on_time_addr = 4'hc;
	// The mode control register sits past the four timing registers.
	localparam logic [4:0] mode_ctrl_addr   = 5'h10;

	// Field position of the independent-mode select in the mode control register.
	localparam int mode_indep_bit = 8;

	// Reset values of the timing registers.
	localparam logic [7:0] period_reset  = 8'hff;
	localparam logic [7:0] on_time_reset = 8'h00;

	// Reset value of the mode select: offset mode.
	localparam logic mode_indep_reset = 1'b0;

	// Last phase of the base time step, which lasts two clock cycles.
	localparam logic prescale_last = 1'h1;

	// AXI response codes.
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// Write-side channel pair carried together.
	typedef struct packed {
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic [4:0]  awaddr;
	} dapw_wreq_type;

endpackage

/* design/dapw_top.sv */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module dapw_top (
	// Clock and synchronous reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// AXI4-Lite write address channel.
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data channel.
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address channel.
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data channel.
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// PWM outputs.
	output logic             pwm_output_0,
	output logic             pwm_output_1
);

	// Software-visible registers.
	logic                      mode_indep_reg;       // Independent mode when set.
	logic [7:0]                ch0_period_reg;       // Channel 0 period.
	logic [7:0]                ch1_period_reg;       // Channel 1 period or offset.
	logic [7:0]                ch0_on_reg;           // Channel 0 on-time as written.
	logic [7:0]                ch1_on_reg;           // Channel 1 on-time as written.

	// Bus slave state.
	logic                      aw_held_reg;          // Write address captured.
	logic                      w_held_reg;           // Write data captured.
	logic [4:0]                aw_addr_reg;          // Captured write address.
	logic [31:0]               w_data_reg;           // Captured write data.
	logic [3:0]                w_strb_reg;           // Captured byte enables.
	dapw_pkg::dapw_wreq_type   wreq;                 // Joined write request.
	logic                      wr_fire;              // Write performed this cycle.
	logic                      wr_hit;               // Write address is mapped.
	logic [4:0]                wr_addr_full;         // Write address in use, held or live.

	// Generator state.
	logic                      step_reg;             // Half-step phase of the base time step.
	logic                      tick;                 // One pulse per base time step.
	logic [7:0]                cnt0_reg;             // Channel 0 step counter.
	logic [7:0]                cnt1_reg;             // Channel 1 step counter.
	logic [7:0]                act0_on_reg;          // Channel 0 on-time in use.
	logic [7:0]                act1_on_reg;          // Channel 1 on-time in use.
	logic                      period_restart;       // Period write in independent mode.
	logic [7:0]                per1;                 // Period that channel 1 wraps at.
	logic [7:0]                offset_cnt_reg;       // Steps since channel 0 cycle start.
	logic                      offset_armed_reg;     // Waiting for channel 1 start in offset mode.

	// The slave accepts each channel once and holds it until the pair is complete.
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// The write fires once both address and data have arrived, in either order.
	always_comb begin
		wreq.awaddr = wr_addr_full;
		wreq.wdata  = w_held_reg ? w_data_reg : s_axi_wdata;
		wreq.wstrb  = w_held_reg ? w_strb_reg : s_axi_wstrb;
		wr_fire     = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
			&& (w_held_reg || (s_axi_wvalid && s_axi_wready));
	end

	// Full captured address, used to tell mapped from unmapped locations.
	assign wr_addr_full = aw_held_reg ? aw_addr_reg : s_axi_awaddr[4:0];
	assign wr_hit       = (wr_addr_full[1:0] == 2'h0) && (wr_addr_full <= dapw_pkg::mode_ctrl_addr)
		&& (s_axi_awaddr[31:5] == 27'h0 || aw_held_reg);

	// Address and data holding registers for the write pair.
	always_ff @(posedge clk) begin
		if (rst || wr_fire) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
			end
		end
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_reg <= (s_axi_awaddr[31:5] == 27'h0) ? s_axi_awaddr[4:0] : 5'h1f;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
	end

	// Write response: OKAY for mapped registers, SLVERR otherwise.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dapw_pkg::resp_okay;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? dapw_pkg::resp_okay : dapw_pkg::resp_slverr;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes are taken at any time, whatever the generator is doing.
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_indep_reg <= dapw_pkg::mode_indep_reset;
			ch0_period_reg <= dapw_pkg::period_reset;
			ch1_period_reg <= dapw_pkg::period_reset;
			ch0_on_reg     <= dapw_pkg::on_time_reset;
			ch1_on_reg     <= dapw_pkg::on_time_reset;
		end else if (wr_fire && wr_hit) begin
			case (wreq.awaddr)
				{1'b0, dapw_pkg::ch0_period_addr}: begin
					if (wreq.wstrb[0]) ch0_period_reg <= wreq.wdata[7:0];
				end
				{1'b0, dapw_pkg::ch1_period_addr}: begin
					if (wreq.wstrb[0]) ch1_period_reg <= wreq.wdata[7:0];
				end
				{1'b0, dapw_pkg::ch0_on_time_addr}: begin
					if (wreq.wstrb[0]) ch0_on_reg <= wreq.wdata[7:0];
				end
				{1'b0, dapw_pkg::ch1_on_time_addr}: begin
					if (wreq.wstrb[0]) ch1_on_reg <= wreq.wdata[7:0];
				end
				dapw_pkg::mode_ctrl_addr: begin
					if (wreq.wstrb[1]) mode_indep_reg <= wreq.wdata[dapw_pkg::mode_indep_bit];
				end
				default: begin
				end
			endcase
		end
	end

	// A period write in independent mode restarts both timers.
	assign period_restart = wr_fire && wr_hit && mode_indep_reg && (wreq.wstrb[0])
		&& (wr_addr_full == {1'b0, dapw_pkg::ch0_period_addr}
		|| wr_addr_full == {1'b0, dapw_pkg::ch1_period_addr});

	// Read channel: one word per read, unmapped addresses answer SLVERR with zero data.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= dapw_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= dapw_pkg::resp_okay;
			case (s_axi_araddr)
				{28'h0, dapw_pkg::ch0_period_addr}:  s_axi_rdata <= {24'h0, ch0_period_reg};
				{28'h0, dapw_pkg::ch1_period_addr}:  s_axi_rdata <= {24'h0, ch1_period_reg};
				{28'h0, dapw_pkg::ch0_on_time_addr}: s_axi_rdata <= {24'h0, ch0_on_reg};
				{28'h0, dapw_pkg::ch1_on_time_addr}: s_axi_rdata <= {24'h0, ch1_on_reg};
				{27'h0, dapw_pkg::mode_ctrl_addr}: begin
					// Bits 16 and 17 show the live output levels.
					s_axi_rdata <= {14'h0, pwm_output_1, pwm_output_0, 7'h0, mode_indep_reg, 8'h0};
				end
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= dapw_pkg::resp_slverr;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Base time step of two clock cycles.
	always_ff @(posedge clk) begin
		if (rst || period_restart) begin
			step_reg <= 1'b0;
		end else begin
			step_reg <= ~step_reg;
		end
	end
	assign tick = (step_reg == dapw_pkg::prescale_last);

	// Channel 1 wraps at its own period only in independent mode.
	assign per1 = mode_indep_reg ? ch1_period_reg : ch0_period_reg;

	// Channel 0 counter and on-time latch; counts 0..period then wraps.
	always_ff @(posedge clk) begin
		if (rst || period_restart) begin
			cnt0_reg    <= 8'h0;
			act0_on_reg <= rst ? dapw_pkg::on_time_reset : ch0_on_reg;
		end else if (tick) begin
			if (cnt0_reg >= ch0_period_reg) begin
				cnt0_reg    <= 8'h0;
				act0_on_reg <= ch0_on_reg;
			end else begin
				cnt0_reg <= cnt0_reg + 8'h1;
			end
		end
	end

	// Offset tracker: channel 1 starts value-plus-one steps after channel 0 starts.
	always_ff @(posedge clk) begin
		if (rst || period_restart || mode_indep_reg) begin
			offset_cnt_reg   <= 8'h0;
			offset_armed_reg <= 1'b0;
		end else if (tick) begin
			if (cnt0_reg >= ch0_period_reg) begin
				offset_cnt_reg   <= 8'h0;
				offset_armed_reg <= 1'b1;
			end else if (offset_armed_reg) begin
				offset_cnt_reg <= offset_cnt_reg + 8'h1;
				if (offset_cnt_reg == ch1_period_reg) begin
					offset_armed_reg <= 1'b0;
				end
			end
		end
	end

	// Channel 1 counter and on-time latch.
	always_ff @(posedge clk) begin
		if (rst || period_restart) begin
			cnt1_reg    <= 8'h0;
			act1_on_reg <= rst ? dapw_pkg::on_time_reset : ch1_on_reg;
		end else if (tick) begin
			if (!mode_indep_reg && offset_armed_reg && offset_cnt_reg == ch1_period_reg) begin
				cnt1_reg    <= 8'h0;
				act1_on_reg <= ch1_on_reg;
			end else if (cnt1_reg >= per1) begin
				cnt1_reg    <= 8'h0;
				act1_on_reg <= ch1_on_reg;
			end else begin
				cnt1_reg <= cnt1_reg + 8'h1;
			end
		end
	end

	// Outputs: high while count is below on-time; on-time above period keeps it high.
	always_ff @(posedge clk) begin
		if (rst) begin
			pwm_output_0 <= 1'b0;
			pwm_output_1 <= 1'b0;
		end else begin
			pwm_output_0 <= (cnt0_reg < act0_on_reg) || (act0_on_reg > ch0_period_reg);
			pwm_output_1 <= (cnt1_reg < act1_on_reg) || (act1_on_reg > per1);
		end
	end

	// Zero on-time never drives channel 0 high.
	property p_zero_low;
		@(posedge clk) disable iff (rst)
		(act0_on_reg == 8'h0) [*2] |-> !pwm_output_0;
	endproperty
	a_zero_low: assert property (p_zero_low) else $error("output 0 high with zero on-time");

	// Counter never exceeds channel 0 period once stable.
	property p_wrap;
		@(posedge clk) disable iff (rst)
		$stable(ch0_period_reg) && tick && cnt0_reg >= ch0_period_reg |=> cnt0_reg == 8'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("channel 0 counter did not wrap");

	// Restart clears counters.
	property p_restart;
		@(posedge clk) disable iff (rst)
		period_restart |=> (cnt0_reg == 8'h0 && cnt1_reg == 8'h0);
	endproperty
	a_restart: assert property (p_restart) else $error("period write did not restart");

	// Full duty when on-time exceeds period.
	property p_full;
		@(posedge clk) disable iff (rst)
		(act0_on_reg > ch0_period_reg) [*2] |-> pwm_output_0;
	endproperty
	a_full: assert property (p_full) else $error("output 0 not held high");

	// Every software register holds its reset value in the first cycle after reset.
	property p_reset_state;
		@(posedge clk) disable iff (rst)
		$past(rst) |-> (mode_indep_reg == dapw_pkg::mode_indep_reset
			&& ch0_period_reg == dapw_pkg::period_reset && ch1_period_reg == dapw_pkg::period_reset
			&& ch0_on_reg == dapw_pkg::on_time_reset && ch1_on_reg == dapw_pkg::on_time_reset);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("register not at reset value");

	// Channel 0 starts a new cycle while offset mode is selected.
	sequence s_ch0_wrap;
		!mode_indep_reg && tick && cnt0_reg >= ch0_period_reg;
	endsequence

	// Offset mode with a zero offset stays in force for the next two cycles.
	sequence s_zero_offset;
		(!mode_indep_reg && ch1_period_reg == 8'h0) [*2];
	endsequence

	// With a zero offset, channel 1 restarts one base step after channel 0 does.
	property p_offset_zero;
		@(posedge clk) disable iff (rst)
		s_ch0_wrap ##1 s_zero_offset |=> cnt1_reg == 8'h0;
	endproperty
	a_offset_zero: assert property (p_offset_zero) else $error("channel 1 offset start missed");

endmodule

/* bench/dapw_load_model.sv */
`timescale 1ns/10ps
// Passive load on both outputs, such as a converter stage or an output filter.
// It measures each output's period and high time, and the delay between the two rising edges.
module dapw_load_model (
	// Clock.
	input  wire logic        clk,
	// Observed outputs.
	input  wire logic        pwm_output_0,
	input  wire logic        pwm_output_1,
	// Last measurements, in clock cycles.
	output logic      [15:0] per0,
	output logic      [15:0] hi0,
	output logic      [15:0] per1,
	output logic      [15:0] hi1,
	output logic      [15:0] delay01
);
	logic [15:0] c0 = 16'h0;  // Cycles since the last rise of output 0.
	logic [15:0] c1 = 16'h0;  // Cycles since the last rise of output 1.
	logic [15:0] cd = 16'h0;  // Cycles since the last rise of output 0, for the edge delay.
	logic        p0 = 1'h0;   // Output 0 one cycle earlier.
	logic        p1 = 1'h0;   // Output 1 one cycle earlier.

	// Counts restart at each rise, so a rise or a fall sees the length of what has just ended.
	always @(posedge clk) begin
		c0 <= c0 + 16'h1;
		c1 <= c1 + 16'h1;
		cd <= cd + 16'h1;
		if (pwm_output_0 && !p0) begin
			per0 <= c0;
			c0   <= 16'h1;
			cd   <= 16'h1;
		end
		if (!pwm_output_0 && p0) begin
			hi0 <= c0;
		end
		if (pwm_output_1 && !p1) begin
			per1    <= c1;
			c1      <= 16'h1;
			delay01 <= cd;
		end
		if (!pwm_output_1 && p1) begin
			hi1 <= c1;
		end
		p0 <= pwm_output_0;
		p1 <= pwm_output_1;
	end
endmodule

/* bench/tb.sv */
`timescale 1ns/10ps
// Register-level tests of the auxiliary PWM block over its AXI4-Lite port.
module tb;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, pwm0, pwm1;
	logic [1:0]  bresp, rresp;
	logic [15:0] per0, hi0, per1, hi1, delay01;
	int          err_total = 0, n_checks = 0, cyc = 0, hc0, hc1;
	logic [31:0] rd;
	logic [1:0]  rr, br;

	// Clock at 250 MHz.
	always #2 clk = ~clk;

	dapw_top dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pwm_output_0(pwm0), .pwm_output_1(pwm1));

	dapw_load_model load (.clk(clk), .pwm_output_0(pwm0), .pwm_output_1(pwm1), .per0(per0),
		.hi0(hi0), .per1(per1), .hi1(hi1), .delay01(delay01));

	// Compares one value and counts the comparison.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One write; address and data are released each on its own acceptance.
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic ad, wd;
		@(posedge clk);
		ad = 1'h0;
		wd = 1'h0;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && awready) begin
				ad = 1'h1;
				awvalid <= 1'h0;
			end
			if (!wd && wready) begin
				wd = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do @(posedge clk); while (!bvalid);
		br = bresp;
		bready <= 1'h0;
	endtask

	// One read; data and response are taken at the edge where rvalid is seen.
	task rdr(input logic [31:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'h0;
		do @(posedge clk); while (!rvalid);
		rd = rdata;
		rr = rresp;
		rready <= 1'h0;
	endtask

	// Prints the counts and the verdict, then stops.
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim;
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		// Reset values, the mode bit, and an unmapped read.
		rdr(32'h0); chk(rd, 32'hff);
		chk(rr, dapw_pkg::resp_okay);
		rdr(32'h4); chk(rd, 32'hff);
		rdr(32'h8); chk(rd, 32'h0);
		rdr(32'hc); chk(rd, 32'h0);
		rdr(32'h10); chk(rd[8], 1'h0);
		rdr(32'h20); chk(rr, dapw_pkg::resp_slverr);
		chk(rd, 32'h0);
		wr(32'h14, 32'h1); chk(br, dapw_pkg::resp_slverr);
		$display("test 1 done");
		// Independent mode: each output with its own period and on-time.
		wr(32'h10, 32'h100);
		chk(br, dapw_pkg::resp_okay);
		rdr(32'h10); chk(rd[8], 1'h1);
		wr(32'h8, 32'h2);
		wr(32'hc, 32'h3);
		wr(32'h0, 32'h4);
		wr(32'h4, 32'h9);
		repeat (80) @(posedge clk);
		chk(per0, 32'd10);
		chk(hi0, 32'd4);
		chk(per1, 32'd20);
		chk(hi1, 32'd6);
		$display("test 2 done");
		// On-time above the period gives a full-high output, zero a full-low one.
		wr(32'h8, 32'h8);
		wr(32'hc, 32'h0);
		repeat (50) @(posedge clk);
		hc0 = 0;
		hc1 = 0;
		repeat (40) begin
			@(posedge clk);
			hc0 += int'(pwm0 === 1'h1);
			hc1 += int'(pwm1 !== 1'h0);
		end
		chk(hc0, 32'd40);
		chk(hc1, 32'd0);
		rdr(32'h10); chk(rd[17:16], 2'h1);
		$display("test 3 done");
		// Offset mode: shared period, rising-edge delay set by the second period register.
		wr(32'h10, 32'h0);
		wr(32'h8, 32'h2);
		wr(32'hc, 32'h3);
		wr(32'h0, 32'h9);
		wr(32'h4, 32'h3);
		repeat (80) @(posedge clk);
		chk(per0, 32'd20);
		chk(per1, 32'd20);
		chk(hi1, 32'd6);
		chk(delay01, 32'd8);
		$display("test 4 done");
		// Zero offset: output 1 rises two cycles after output 0.
		wr(32'h4, 32'h0);
		repeat (80) @(posedge clk);
		chk(delay01, 32'd2);
		chk(per1, 32'd20);
		$display("test 5 done");
		end_sim;
	end
endmodule
